//--- inc/pmp_pkg.sv
// Shared constants for the MII port: clock rates, divider counts, widths.
package pmp_pkg;
   // ------------------------------------------------------------
   // Core clock and timing
   // ------------------------------------------------------------
   localparam int CORE_MHZ = 20;
   localparam int HB_NS = 1000;
   localparam int HB_CYC = (HB_NS * CORE_MHZ) / 1000;
   localparam int MDC_MAX_MHZ = 25;
   // ------------------------------------------------------------
   // Scaled MII clock dividers (half periods in core cycles)
   // ------------------------------------------------------------
   localparam int HALF_100 = 4;
   localparam int HALF_10 = 40;
   localparam int MDC_HALF = 4;
   localparam int CNT_W = 8;
   // ------------------------------------------------------------
   // Data path widths and layout
   // ------------------------------------------------------------
   localparam int NIB_W = 4;
   localparam int TXW_W = NIB_W + 1;
   localparam int TXW_ER = NIB_W;
   localparam int FIFO_DEPTH = 2;
   localparam logic [NIB_W-1:0] HALT_NIB = 4'h0;
endpackage

//--- inc/pmp_mii_if.sv
// MII pins between the transceiver end and the MAC end.
`timescale 1ns/1ns
interface pmp_mii_if;
   logic tx_clk;
   logic [3:0] txd;
   logic tx_en;
   logic tx_er;
   logic rx_clk;
   logic [3:0] rxd;
   logic rx_dv;
   logic rx_er;
   logic crs;
   logic col;
   logic mdc;
   logic mdio_mac_o;
   logic mdio_mac_oe;
   logic mdio_phy_o;
   logic mdio_phy_oe;
   logic mdio;

   // Open-drain line with pull-up: low when any enabled driver pulls low
   assign mdio = !((mdio_mac_oe && !mdio_mac_o) || (mdio_phy_oe && !mdio_phy_o));

   modport phy (
      output tx_clk, rx_clk, rxd, rx_dv, rx_er, crs, col, mdio_phy_o, mdio_phy_oe,
      input txd, tx_en, tx_er, mdc, mdio
   );
   modport mac (
      input tx_clk, rx_clk, rxd, rx_dv, rx_er, crs, col, mdio,
      output txd, tx_en, tx_er, mdc, mdio_mac_o, mdio_mac_oe
   );
endinterface

//--- verilog/pmp_phy_end.sv
// Transceiver end of the MII port: clocks, carrier, collision, data and management.
`timescale 1ns/1ns
module pmp_phy_end #(
   parameter int HALF_100 = pmp_pkg::HALF_100,
   parameter int HALF_10 = pmp_pkg::HALF_10,
   parameter int HB_CYC = pmp_pkg::HB_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // MII pins
   pmp_mii_if.phy mii,
   // Mode configuration
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic hb_en,
   // Line receive side
   input wire logic line_rx_valid,
   input wire logic [pmp_pkg::NIB_W-1:0] line_rx_nibble,
   input wire logic line_rx_code_err,
   output logic line_rx_take,
   // Line transmit side
   output logic line_tx_valid,
   output logic [pmp_pkg::NIB_W-1:0] line_tx_nibble,
   output logic line_tx_halt,
   output logic line_tx_active,
   // Management bits
   output logic mgmt_rx_valid,
   output logic mgmt_rx_bit,
   input wire logic mgmt_tx_en,
   input wire logic mgmt_tx_bit
);
   localparam int SW = 8;
   localparam logic [pmp_pkg::CNT_W-1:0] ONE_CNT = 8'h01;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [SW-1:0] pin_raw;
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   logic [SW-1:0] sync1_d;
   logic [SW-1:0] sync2_d;
   logic s_mdc;
   logic s_mdio;
   logic s_tx_en;
   logic s_tx_er;
   logic [3:0] s_txd;

   // Gather asynchronous MAC-driven pins
   assign pin_raw = {mii.mdc, mii.mdio, mii.tx_en, mii.tx_er, mii.txd};

   // Two flops per pin, second stage is the only reader of the first
   always_comb
   begin
      sync1_d = pin_raw;
      sync2_d = sync1_q;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   assign {s_mdc, s_mdio, s_tx_en, s_tx_er, s_txd} = sync2_q;

   // ------------------------------------------------------------
   // MII clock divider
   // ------------------------------------------------------------
   logic [pmp_pkg::CNT_W-1:0] div_q;
   logic [pmp_pkg::CNT_W-1:0] div_d;
   logic [pmp_pkg::CNT_W-1:0] half_cnt;
   logic mclk_q;
   logic mclk_d;
   logic rise_ev;
   logic fall_ev;

   // Half period chosen by speed
   assign half_cnt = speed_100 ? pmp_pkg::CNT_W'(HALF_100) : pmp_pkg::CNT_W'(HALF_10);
   assign rise_ev = (div_q >= half_cnt - ONE_CNT) && !mclk_q;
   assign fall_ev = (div_q >= half_cnt - ONE_CNT) && mclk_q;

   always_comb
   begin
      div_d = div_q + ONE_CNT;
      mclk_d = mclk_q;
      if (rise_ev || fall_ev)
      begin
         div_d = '0;
         mclk_d = !mclk_q;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         div_q <= '0;
         mclk_q <= 1'b0;
      end
      else
      begin
         div_q <= div_d;
         mclk_q <= mclk_d;
      end
   end

   assign mii.tx_clk = mclk_q;
   assign mii.rx_clk = mclk_q;

   // ------------------------------------------------------------
   // Transmit sampling
   // ------------------------------------------------------------
   logic tx_act_q;
   logic tx_act_d;
   logic ltx_valid_q;
   logic ltx_valid_d;
   logic ltx_halt_q;
   logic ltx_halt_d;
   logic [3:0] ltx_nib_q;
   logic [3:0] ltx_nib_d;

   // Sample data on the transmit clock rise
   always_comb
   begin
      tx_act_d = tx_act_q;
      ltx_valid_d = 1'b0;
      ltx_halt_d = 1'b0;
      ltx_nib_d = ltx_nib_q;
      if (rise_ev)
      begin
         tx_act_d = s_tx_en;
         ltx_valid_d = s_tx_en;
         if (s_tx_en)
         begin
            ltx_halt_d = speed_100 && s_tx_er;
            ltx_nib_d = (speed_100 && s_tx_er) ? pmp_pkg::HALT_NIB : s_txd;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         tx_act_q <= 1'b0;
         ltx_valid_q <= 1'b0;
         ltx_halt_q <= 1'b0;
         ltx_nib_q <= '0;
      end
      else
      begin
         tx_act_q <= tx_act_d;
         ltx_valid_q <= ltx_valid_d;
         ltx_halt_q <= ltx_halt_d;
         ltx_nib_q <= ltx_nib_d;
      end
   end

   assign line_tx_valid = ltx_valid_q;
   assign line_tx_halt = ltx_halt_q;
   assign line_tx_nibble = ltx_nib_q;
   assign line_tx_active = tx_act_q;

   // ------------------------------------------------------------
   // Receive presentation
   // ------------------------------------------------------------
   logic [3:0] rxd_q;
   logic [3:0] rxd_d;
   logic rx_dv_q;
   logic rx_dv_d;
   logic rx_er_q;
   logic rx_er_d;
   logic take_q;
   logic take_d;

   // Update receive pins on the receive clock fall
   always_comb
   begin
      rxd_d = rxd_q;
      rx_dv_d = rx_dv_q;
      rx_er_d = rx_er_q;
      take_d = 1'b0;
      if (fall_ev)
      begin
         rxd_d = line_rx_valid ? line_rx_nibble : '0;
         rx_dv_d = line_rx_valid;
         rx_er_d = speed_100 && line_rx_valid && line_rx_code_err;
         take_d = line_rx_valid;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rxd_q <= '0;
         rx_dv_q <= 1'b0;
         rx_er_q <= 1'b0;
         take_q <= 1'b0;
      end
      else
      begin
         rxd_q <= rxd_d;
         rx_dv_q <= rx_dv_d;
         rx_er_q <= rx_er_d;
         take_q <= take_d;
      end
   end

   assign mii.rxd = rxd_q;
   assign mii.rx_dv = rx_dv_q;
   assign mii.rx_er = rx_er_q;
   assign line_rx_take = take_q;

   // ------------------------------------------------------------
   // Carrier sense, collision, heartbeat
   // ------------------------------------------------------------
   logic crs_q;
   logic crs_d;
   logic col_q;
   logic col_d;
   logic [pmp_pkg::CNT_W-1:0] hb_q;
   logic [pmp_pkg::CNT_W-1:0] hb_d;
   logic tx_end;

   assign tx_end = rise_ev && tx_act_q && !s_tx_en;

   // Form carrier and collision from activity
   always_comb
   begin
      hb_d = hb_q;
      if (hb_q != '0)
         hb_d = hb_q - ONE_CNT;
      if (tx_end && !speed_100 && !full_duplex && hb_en)
         hb_d = pmp_pkg::CNT_W'(HB_CYC);
      if (full_duplex)
         hb_d = '0;
      crs_d = full_duplex ? line_rx_valid : (line_rx_valid || tx_act_q);
      col_d = !full_duplex && ((line_rx_valid && tx_act_q) || (hb_d != '0));
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         crs_q <= 1'b0;
         col_q <= 1'b0;
         hb_q <= '0;
      end
      else
      begin
         crs_q <= crs_d;
         col_q <= col_d;
         hb_q <= hb_d;
      end
   end

   assign mii.crs = crs_q;
   assign mii.col = col_q;

   // ------------------------------------------------------------
   // Management bit port
   // ------------------------------------------------------------
   logic mdc_last_q;
   logic mdc_last_d;
   logic mrx_v_q;
   logic mrx_v_d;
   logic mrx_b_q;
   logic mrx_b_d;
   logic md_oe_q;
   logic md_oe_d;

   // Sample on management clock rise, drive after its fall
   always_comb
   begin
      mdc_last_d = s_mdc;
      mrx_v_d = s_mdc && !mdc_last_q;
      mrx_b_d = (s_mdc && !mdc_last_q) ? s_mdio : mrx_b_q;
      md_oe_d = md_oe_q;
      if (!s_mdc && mdc_last_q)
         md_oe_d = mgmt_tx_en && !mgmt_tx_bit;
      if (!mgmt_tx_en)
         md_oe_d = 1'b0;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         mdc_last_q <= 1'b0;
         mrx_v_q <= 1'b0;
         mrx_b_q <= 1'b0;
         md_oe_q <= 1'b0;
      end
      else
      begin
         mdc_last_q <= mdc_last_d;
         mrx_v_q <= mrx_v_d;
         mrx_b_q <= mrx_b_d;
         md_oe_q <= md_oe_d;
      end
   end

   assign mgmt_rx_valid = mrx_v_q;
   assign mgmt_rx_bit = mrx_b_q;
   assign mii.mdio_phy_o = 1'b0;
   assign mii.mdio_phy_oe = md_oe_q;
endmodule // pmp_phy_end

//--- verilog/pmp_mac_end.sv
// MAC end of the MII port: buffered transmit, receive capture, management clock.
`timescale 1ns/1ns
module pmp_mac_end #(
   parameter int MDC_HALF = pmp_pkg::MDC_HALF
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // MII pins
   pmp_mii_if.mac mii,
   // Transmit stream
   input wire logic tx_valid,
   input wire logic [pmp_pkg::NIB_W-1:0] tx_nibble,
   input wire logic tx_err,
   output logic tx_ready,
   // Receive stream
   output logic rx_valid,
   output logic [pmp_pkg::NIB_W-1:0] rx_nibble,
   output logic rx_err,
   output logic crs,
   output logic col,
   // Management bits
   input wire logic mgmt_tx_valid,
   input wire logic mgmt_tx_bit,
   output logic mgmt_tx_taken,
   output logic mgmt_rx_valid,
   output logic mgmt_rx_bit
);
   localparam int SW = 10;
   localparam int TW = pmp_pkg::TXW_W;
   localparam logic [pmp_pkg::CNT_W-1:0] ONE_CNT = 8'h01;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   logic s_txc, s_rxc, s_dv, s_er, s_crs, s_col;
   logic [3:0] s_rxd;

   // Two flops per pin from the transceiver
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= {mii.tx_clk, mii.rx_clk, mii.rx_dv, mii.rx_er, mii.crs, mii.col, mii.rxd};
         sync2_q <= sync1_q;
      end
   end

   assign {s_txc, s_rxc, s_dv, s_er, s_crs, s_col, s_rxd} = sync2_q;

   // ------------------------------------------------------------
   // Transmit buffer, two entries
   // ------------------------------------------------------------
   logic [TW-1:0] buf_q [pmp_pkg::FIFO_DEPTH];
   logic [TW-1:0] buf_d [pmp_pkg::FIFO_DEPTH];
   logic [1:0] fill_q, fill_d;
   logic txc_last_q;
   logic [3:0] txd_q, txd_d;
   logic tx_en_q, tx_en_d, tx_er_q, tx_er_d;
   logic push, pop, txc_rise;
   logic ready_q, ready_d;

   assign txc_rise = s_txc && !txc_last_q;
   assign pop = txc_rise && (fill_q != 2'h0);
   assign push = tx_valid && (fill_q != 2'(pmp_pkg::FIFO_DEPTH));

   // Drain one word per transmit clock rise, fill from the stream
   always_comb
   begin
      buf_d = buf_q;
      fill_d = fill_q;
      txd_d = txd_q;
      tx_en_d = tx_en_q;
      tx_er_d = tx_er_q;
      if (txc_rise)
      begin
         tx_en_d = pop;
         txd_d = pop ? buf_q[0][pmp_pkg::NIB_W-1:0] : '0;
         tx_er_d = pop && buf_q[0][pmp_pkg::TXW_ER];
      end
      if (pop)
      begin
         buf_d[0] = buf_q[1];
         fill_d = fill_q - 2'h1;
      end
      if (push)
      begin
         buf_d[fill_d[0]] = {tx_err, tx_nibble};
         fill_d = fill_d + 2'h1;
      end
      // Ready registered from the next fill level
      ready_d = (fill_d != 2'(pmp_pkg::FIFO_DEPTH));
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         buf_q <= '{default: '0};
         fill_q <= '0;
         ready_q <= 1'b1;
         txc_last_q <= 1'b0;
         txd_q <= '0;
         tx_en_q <= 1'b0;
         tx_er_q <= 1'b0;
      end
      else
      begin
         buf_q <= buf_d;
         fill_q <= fill_d;
         ready_q <= ready_d;
         txc_last_q <= s_txc;
         txd_q <= txd_d;
         tx_en_q <= tx_en_d;
         tx_er_q <= tx_er_d;
      end
   end

   assign tx_ready = ready_q;
   assign mii.txd = txd_q;
   assign mii.tx_en = tx_en_q;
   assign mii.tx_er = tx_er_q;

   // ------------------------------------------------------------
   // Receive capture on receive clock rise
   // ------------------------------------------------------------
   logic rxc_last_q, rxv_q, rxv_d, rxe_q, rxe_d, crs_q, col_q;
   logic [3:0] rxn_q, rxn_d;

   always_comb
   begin
      rxv_d = s_rxc && !rxc_last_q && s_dv;
      rxn_d = rxv_d ? s_rxd : rxn_q;
      rxe_d = rxv_d && s_er;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rxc_last_q <= 1'b0;
         rxv_q <= 1'b0;
         rxn_q <= '0;
         rxe_q <= 1'b0;
         crs_q <= 1'b0;
         col_q <= 1'b0;
      end
      else
      begin
         rxc_last_q <= s_rxc;
         rxv_q <= rxv_d;
         rxn_q <= rxn_d;
         rxe_q <= rxe_d;
         crs_q <= s_crs;
         col_q <= s_col;
      end
   end

   assign rx_valid = rxv_q;
   assign rx_nibble = rxn_q;
   assign rx_err = rxe_q;
   assign crs = crs_q;
   assign col = col_q;

   // ------------------------------------------------------------
   // Management clock and bit port
   // ------------------------------------------------------------
   logic [pmp_pkg::CNT_W-1:0] mdiv_q, mdiv_d;
   logic mdc_q, mdc_d, moe_q, moe_d, mtk_q, mtk_d, mrv_q, mrv_d, mrb_q, mrb_d;
   logic mdio_s1_q, mdio_s2_q, mdc_edge;

   assign mdc_edge = (mdiv_q >= pmp_pkg::CNT_W'(MDC_HALF) - ONE_CNT);

   always_comb
   begin
      mdiv_d = mdc_edge ? '0 : mdiv_q + ONE_CNT;
      mdc_d = mdc_edge ? !mdc_q : mdc_q;
      moe_d = moe_q;
      mtk_d = 1'b0;
      mrv_d = mdc_edge && !mdc_q;
      mrb_d = (mdc_edge && !mdc_q) ? mdio_s2_q : mrb_q;
      if (mdc_edge && mdc_q)
      begin
         moe_d = mgmt_tx_valid && !mgmt_tx_bit;
         mtk_d = mgmt_tx_valid;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         mdiv_q <= '0;
         mdc_q <= 1'b0;
         moe_q <= 1'b0;
         mtk_q <= 1'b0;
         mrv_q <= 1'b0;
         mrb_q <= 1'b0;
         mdio_s1_q <= 1'b1;
         mdio_s2_q <= 1'b1;
      end
      else
      begin
         mdiv_q <= mdiv_d;
         mdc_q <= mdc_d;
         moe_q <= moe_d;
         mtk_q <= mtk_d;
         mrv_q <= mrv_d;
         mrb_q <= mrb_d;
         mdio_s1_q <= mii.mdio;
         mdio_s2_q <= mdio_s1_q;
      end
   end

   assign mii.mdc = mdc_q;
   assign mii.mdio_mac_o = 1'b0;
   assign mii.mdio_mac_oe = moe_q;
   assign mgmt_tx_taken = mtk_q;
   assign mgmt_rx_valid = mrv_q;
   assign mgmt_rx_bit = mrb_q;
endmodule // pmp_mac_end

//--- test/pmp_mii_monitor.sv
// Checker for the MII pins joining the two ends.
`timescale 1ns/1ns
module pmp_mii_monitor #(
   parameter int HALF_100 = pmp_pkg::HALF_100,
   parameter int HALF_10 = pmp_pkg::HALF_10
) (
   // Clock, reset and mode
   input wire logic core_clk,
   input wire logic srst,
   input wire logic speed_100,
   input wire logic full_duplex,
   // MII pins
   input wire logic tx_clk,
   input wire logic rx_clk,
   input wire logic [3:0] txd,
   input wire logic tx_en,
   input wire logic [3:0] rxd,
   input wire logic rx_dv,
   input wire logic rx_er,
   input wire logic col,
   input wire logic mdio,
   input wire logic mdio_mac_oe,
   input wire logic mdio_phy_oe
);
   logic prev_q, prev_d, seen_q, seen_d;
   logic [7:0] cnt_q, cnt_d;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   // ------------------------------------------------------------
   // Half period counter of the transmit clock
   // ------------------------------------------------------------
   // Next values: count since the last edge of the clock
   always_comb
   begin
      prev_d = tx_clk;
      seen_d = seen_q | (tx_clk != prev_q);
      cnt_d = (tx_clk != prev_q) ? 8'h00 : cnt_q + 8'h01;
   end
   // Registers
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         prev_q <= 1'h0;
         seen_q <= 1'h0;
         cnt_q <= 8'h00;
      end
      else
      begin
         prev_q <= prev_d;
         seen_q <= seen_d;
         cnt_q <= cnt_d;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_clk_half;
      (tx_clk != prev_q) && seen_q |-> cnt_q == (speed_100 ? HALF_100 - 1 : HALF_10 - 1);
   endproperty
   a_clk_half: assert property (p_clk_half)
      else $error("transmit clock half period wrong");
   property p_rx_clk;
      rx_clk == tx_clk;
   endproperty
   a_rx_clk: assert property (p_rx_clk)
      else $error("receive clock differs from transmit clock");
   property p_tx_chg;
      $changed(tx_en) || $changed(txd) |-> tx_clk || $past(tx_clk);
   endproperty
   a_tx_chg: assert property (p_tx_chg)
      else $error("transmit pins changed in low clock phase");
   property p_rxd_fall;
      $changed(rxd) |-> !rx_clk;
   endproperty
   a_rxd_fall: assert property (p_rxd_fall)
      else $error("receive nibble changed while clock high");
   property p_rxdv_fall;
      $changed(rx_dv) |-> !rx_clk;
   endproperty
   a_rxdv_fall: assert property (p_rxdv_fall)
      else $error("receive valid changed while clock high");
   property p_rx_er_10;
      !speed_100 |-> !rx_er;
   endproperty
   a_rx_er_10: assert property (p_rx_er_10)
      else $error("receive error high at low speed");
   property p_fd_col;
      full_duplex |-> !col;
   endproperty
   a_fd_col: assert property (p_fd_col)
      else $error("collision high in full duplex");
   property p_mdio_low;
      mdio_mac_oe || mdio_phy_oe |-> !mdio;
   endproperty
   a_mdio_low: assert property (p_mdio_low)
      else $error("management line not pulled low");
   property p_mdio_idle;
      !mdio_mac_oe && !mdio_phy_oe |-> mdio;
   endproperty
   a_mdio_idle: assert property (p_mdio_idle)
      else $error("management line not high when released");
endmodule // pmp_mii_monitor

//--- test/tb.sv
// Testbench for both ends of the MII port.
`timescale 1ns/1ns
module tb;
   typedef struct packed {logic spd, fd, hb, err, rx, crs, col, hb_on;} pmp_row_s;
   localparam logic [3:0] FRAME [3] = '{4'h5, 4'ha, 4'h3};
   // Columns: speed, duplex, heartbeat, tx error, rx on, crs, col, heartbeat seen
   localparam pmp_row_s ROWS [8] = '{8'h84, 8'h9e, 8'hc0, 8'hdc, 8'h35, 8'h0e, 8'h60, 8'h2f};
   logic core_clk, srst, speed_100, full_duplex, hb_en, line_rx_valid, line_rx_code_err;
   logic line_rx_take, line_tx_valid, line_tx_halt, line_tx_active, saw_full;
   logic phy_mrx_v, phy_mrx_b, phy_mtx_en, phy_mtx_b, tx_valid, tx_err, tx_ready;
   logic rx_valid, rx_err, mac_crs, mac_col, mac_mtx_v, mac_mtx_b, mac_taken, mac_mrx_v, mac_mrx_b;
   logic [3:0] line_rx_nibble, line_tx_nibble, tx_nibble, rx_nibble;
   logic [3:0] got_nib [8], rx_nib [8];
   logic got_halt [8], rx_e [8];
   logic [15:0] hb_cnt;
   logic [7:0] pat;
   pmp_row_s row;
   int error_cnt, total_checks, cyc, got_n, rx_n;

   pmp_mii_if mii();
   pmp_phy_end i_pmp_phy_end (.core_clk(core_clk), .srst(srst), .mii(mii),
      .speed_100(speed_100), .full_duplex(full_duplex), .hb_en(hb_en),
      .line_rx_valid(line_rx_valid), .line_rx_nibble(line_rx_nibble),
      .line_rx_code_err(line_rx_code_err), .line_rx_take(line_rx_take),
      .line_tx_valid(line_tx_valid), .line_tx_nibble(line_tx_nibble),
      .line_tx_halt(line_tx_halt), .line_tx_active(line_tx_active),
      .mgmt_rx_valid(phy_mrx_v), .mgmt_rx_bit(phy_mrx_b),
      .mgmt_tx_en(phy_mtx_en), .mgmt_tx_bit(phy_mtx_b));
   pmp_mac_end i_pmp_mac_end (.core_clk(core_clk), .srst(srst), .mii(mii),
      .tx_valid(tx_valid), .tx_nibble(tx_nibble), .tx_err(tx_err), .tx_ready(tx_ready),
      .rx_valid(rx_valid), .rx_nibble(rx_nibble), .rx_err(rx_err), .crs(mac_crs),
      .col(mac_col), .mgmt_tx_valid(mac_mtx_v), .mgmt_tx_bit(mac_mtx_b),
      .mgmt_tx_taken(mac_taken), .mgmt_rx_valid(mac_mrx_v), .mgmt_rx_bit(mac_mrx_b));
   pmp_mii_monitor i_pmp_mii_monitor (.core_clk(core_clk), .srst(srst),
      .speed_100(speed_100), .full_duplex(full_duplex), .tx_clk(mii.tx_clk),
      .rx_clk(mii.rx_clk), .txd(mii.txd), .tx_en(mii.tx_en), .rxd(mii.rxd),
      .rx_dv(mii.rx_dv), .rx_er(mii.rx_er), .col(mii.col), .mdio(mii.mdio),
      .mdio_mac_oe(mii.mdio_mac_oe), .mdio_phy_oe(mii.mdio_phy_oe));

   // Clock
   always #25 core_clk = ~core_clk;

   // Collect line words and received nibbles, cut a hang short
   always @(posedge core_clk)
   begin
      cyc++;
      if (line_tx_valid === 1'h1 && got_n < 8)
      begin
         got_nib[got_n] = line_tx_nibble;
         got_halt[got_n] = line_tx_halt;
         got_n++;
      end
      if (rx_valid === 1'h1 && rx_n < 8)
      begin
         rx_nib[rx_n] = rx_nibble;
         rx_e[rx_n] = rx_err;
         rx_n++;
      end
      if (cyc == 40000)
      begin
         error_cnt++;
         conclude();
      end
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("Checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Reset both ends into one mode
   task automatic reset_dut(input logic spd, input logic fd, input logic hb);
      srst <= 1'h1;
      speed_100 <= spd;
      full_duplex <= fd;
      hb_en <= hb;
      repeat (3) @(posedge core_clk);
      got_n = 0;
      rx_n = 0;
      srst <= 1'h0;
      repeat (2) @(posedge core_clk);
   endtask

   // Send the frame through the two-entry buffer
   task automatic push();
      for (int i = 0; i < 3; i++)
      begin
         tx_valid <= 1'h1;
         tx_nibble <= FRAME[i];
         do
         begin
            @(posedge core_clk);
            if (tx_ready !== 1'h1)
               saw_full = 1'h1;
         end
         while (tx_ready !== 1'h1);
      end
      tx_valid <= 1'h0;
   endtask

   initial
   begin
      {core_clk, speed_100, full_duplex, hb_en, line_rx_valid, line_rx_code_err} = 6'h00;
      {phy_mtx_en, phy_mtx_b, tx_valid, tx_err, mac_mtx_v, mac_mtx_b, saw_full} = 7'h00;
      line_rx_nibble = 4'h0;
      tx_nibble = 4'h0;
      srst = 1'h1;
      repeat (2) @(posedge core_clk);
      check("ready_rst", 16'(tx_ready), 16'h0001);
      check("clk_rst", 16'({mii.tx_clk, mii.crs, mii.col, mii.mdio}), 16'h0001);
      // Mode table: transmit with optional receive overlap
      for (int r = 0; r < 8; r++)
      begin
         row = ROWS[r];
         reset_dut(row.spd, row.fd, row.hb);
         tx_err <= row.err;
         saw_full = 1'h0;
         fork
            push();
            begin
               do @(posedge core_clk); while (line_tx_active !== 1'h1);
               line_rx_valid <= row.rx;
               repeat (3) @(posedge core_clk);
               check("crs", 16'(mii.crs), 16'(row.crs));
               check("col", 16'(mii.col), 16'(row.col));
               repeat (3) @(posedge core_clk);
               check("mac_crs", 16'(mac_crs), 16'(row.crs));
               check("mac_col", 16'(mac_col), 16'(row.col));
               if (row.rx)
                  do @(posedge core_clk); while (line_rx_take !== 1'h1);
               line_rx_valid <= 1'h0;
               repeat (2) @(posedge core_clk);
               hb_cnt = 16'h0000;
               repeat (440)
               begin
                  @(posedge core_clk);
                  if (mii.col === 1'h1)
                     hb_cnt++;
               end
               check("heartbeat", hb_cnt, row.hb_on ? 16'(pmp_pkg::HB_CYC) : 16'h0000);
            end
         join
         check("full", 16'(saw_full), 16'h0001);
         check("words", 16'(got_n), 16'h0003);
         for (int i = 0; i < 3; i++)
         begin
            check("halt", 16'(got_halt[i]), 16'(row.spd & row.err));
            check("nibble", 16'(got_nib[i]), 16'((row.spd & row.err) ? pmp_pkg::HALT_NIB : FRAME[i]));
         end
      end
      // Receive with a bad code group at both speeds
      for (int s = 0; s < 2; s++)
      begin
         reset_dut(s[0], 1'h1, 1'h0);
         for (int i = 0; i < 3; i++)
         begin
            line_rx_valid <= 1'h1;
            line_rx_nibble <= FRAME[i];
            line_rx_code_err <= (i == 1);
            do @(posedge core_clk); while (line_rx_take !== 1'h1);
         end
         line_rx_valid <= 1'h0;
         line_rx_code_err <= 1'h0;
         do @(posedge core_clk); while (rx_n < 3);
         for (int i = 0; i < 3; i++)
         begin
            check("rx_nibble", 16'(rx_nib[i]), 16'(FRAME[i]));
            check("rx_err", 16'(rx_e[i]), 16'(s == 1 && i == 1));
         end
      end
      // Management bits from the MAC end to the transceiver end
      pat = 8'ha5;
      mac_mtx_b <= pat[7];
      mac_mtx_v <= 1'h1;
      for (int i = 7; i >= 0; i--)
      begin
         do @(posedge core_clk); while (mac_taken !== 1'h1);
         mac_mtx_b <= (i > 0) ? pat[(i + 7) % 8] : 1'h0;
         mac_mtx_v <= (i > 0);
         do @(posedge core_clk); while (phy_mrx_v !== 1'h1);
         check("phy_mdio", 16'(phy_mrx_b), 16'(pat[i]));
      end
      // Management line driven low by the transceiver end, then released
      for (int k = 0; k < 2; k++)
      begin
         phy_mtx_en <= (k == 0);
         repeat (3)
            do @(posedge core_clk); while (mac_mrx_v !== 1'h1);
         check("mac_mdio", 16'(mac_mrx_b), 16'(k));
      end
      conclude();
   end
endmodule // tb
